// ===== design/bcce_consts.svh
`ifndef BCCE_CONSTS_SVH
`define BCCE_CONSTS_SVH
// primary opcodes, bits 5..0
`define BCCE_OP_RTYPE   6'h3A
`define BCCE_OP_CALL    6'h00
`define BCCE_OP_CMPEQI  6'h20
// extended opcodes, bits 16..11
`define BCCE_OPX_BRET   6'h09
`define BCCE_OPX_CALLR  6'h1D
`define BCCE_OPX_CMPEQ  6'h20
// field positions
`define BCCE_OP_LSB     0
`define BCCE_OPX_LSB    11
`define BCCE_A_LSB      27
`define BCCE_B_LSB      22
`define BCCE_C_LSB      17
`define BCCE_IMMEDIATE_SIXTEEN_LSB  6
`define BCCE_JUMP_TARGET_LSB        6
// link register index and next instruction step
`define BCCE_LINK_IDX   5'h1F
`define BCCE_PC_STEP    32'h0000_0004
`define BCCE_PC_RESET   32'h0000_0000
`define BCCE_ST_RESET   32'h0000_0000
`endif

// ===== design/bcce_decode.sv
`timescale 1ns/10ps
`default_nettype none
`include "bcce_consts.svh"
module bcce_decode (
   // instruction word
   input  wire logic [31:0]        instr,
   // decoded fields
   output var bcce_pkg::bcce_dec_t dec
);
   wire [5:0] op  = instr[`BCCE_OP_LSB +: 6];
   wire [5:0] opx = instr[`BCCE_OPX_LSB +: 6];
   wire       rty = (op == `BCCE_OP_RTYPE);                        // RULE10
   wire       is_bret   = rty && (opx == `BCCE_OPX_BRET);          // RULE10
   wire       is_callr  = rty && (opx == `BCCE_OPX_CALLR);         // RULE10
   wire       is_cmpeq  = rty && (opx == `BCCE_OPX_CMPEQ);         // RULE10
   wire       is_call   = (op == `BCCE_OP_CALL);                   // RULE10
   wire       is_cmpeqi = (op == `BCCE_OP_CMPEQI);                 // RULE10
   assign dec.op = is_bret   ? bcce_pkg::BCCE_BRET   :
                   is_callr  ? bcce_pkg::BCCE_CALLR  :
                   is_cmpeq  ? bcce_pkg::BCCE_CMPEQ  :
                   is_call   ? bcce_pkg::BCCE_CALL   :
                   is_cmpeqi ? bcce_pkg::BCCE_CMPEQI :
                               bcce_pkg::BCCE_NONE;
   assign dec.a_idx = instr[`BCCE_A_LSB +: 5];
   assign dec.b_idx = instr[`BCCE_B_LSB +: 5];
   assign dec.c_idx = instr[`BCCE_C_LSB +: 5];
   assign dec.immediate_sixteen = instr[`BCCE_IMMEDIATE_SIXTEEN_LSB +: 16];
   assign dec.jump_target_field = instr[`BCCE_JUMP_TARGET_LSB +: 26];
endmodule
`default_nettype wire

// ===== design/bcce_exec.sv
// Overview of operation
// RULE1: breakpoint return copies saved status to status, then jumps to return address.
// RULE2: direct call writes program counter plus 4 into link register.
// RULE3: direct call target keeps counter bits 31..28, appends field times four.
// RULE4: the 26-bit jump target field is unsigned, never sign extended.
// RULE5: register call saves counter plus 4 to link, jumps to register A.
// RULE6: register compare writes 1 to register C when A equals B, else 0.
// RULE7: immediate compare sign-extends the 16-bit field to 32 bits.
// RULE8: immediate compare writes 1 to register B on equality, else 0.
// RULE9: software may compare against register zero to get logical negation.
// RULE10: register forms use opcode 0x3a plus extended opcode; immediates own opcode.
`timescale 1ns/10ps
`default_nettype none
`include "bcce_consts.svh"
module bcce_exec (
   // clock and reset
   input  wire logic                clk_sys,
   input  wire logic                resetn,
   // instruction issue
   input  wire logic                instr_valid,
   input  wire logic [31:0]         instr,
   // register file read ports and saved break state
   input  wire logic [31:0]         rd_a_data,
   input  wire logic [31:0]         rd_b_data,
   input  wire logic [31:0]         saved_break_status,
   input  wire logic [31:0]         break_return_address,
   // register read addresses
   output logic [4:0]               rd_a_idx,
   output logic [4:0]               rd_b_idx,
   // register write back
   output bcce_pkg::bcce_wb_t       wb_q,
   // status register and program counter
   output logic [31:0]              status_q,
   output logic                     status_load_q,
   output logic [31:0]              program_counter_q,
   output logic                     redirect_q
);
   bcce_pkg::bcce_dec_t dec;

   bcce_decode u_dec (
      .instr (instr),
      .dec   (dec)
   );

   function automatic logic [31:0] bcce_bool(input logic v);
      return {31'h0000_0000, v};
   endfunction

   // read ports are addressed straight from the instruction
   assign rd_a_idx = dec.a_idx;
   assign rd_b_idx = dec.b_idx;

   wire        go        = instr_valid;
   wire [31:0] link_val  = program_counter_q + `BCCE_PC_STEP;       // RULE2
   wire [31:0] call_tgt  = {program_counter_q[31:28],
                            dec.jump_target_field, 2'b00};      // RULE3 RULE4
   wire [31:0] imm_sext  = {{16{dec.immediate_sixteen[15]}},
                            dec.immediate_sixteen};                 // RULE7
   wire        eq_rr     = (rd_a_data == rd_b_data);                // RULE6 RULE9
   wire        eq_ri     = (rd_a_data == imm_sext);                 // RULE8

   bcce_pkg::bcce_wb_t wb_d;
   logic [31:0]        pc_d;
   logic               redir_d;
   logic               st_ld_d;

   always_comb begin
      wb_d    = '0;
      pc_d    = link_val;
      redir_d = 1'b0;
      st_ld_d = 1'b0;
      if (go) begin
         case (dec.op)
            bcce_pkg::BCCE_BRET: begin
               st_ld_d = 1'b1;                                      // RULE1
               pc_d    = break_return_address;                      // RULE1
               redir_d = 1'b1;
            end
            bcce_pkg::BCCE_CALL: begin
               wb_d    = '{we: 1'b1, idx: `BCCE_LINK_IDX,
                           data: link_val};                         // RULE2
               pc_d    = call_tgt;                                  // RULE3
               redir_d = 1'b1;
            end
            bcce_pkg::BCCE_CALLR: begin
               wb_d    = '{we: 1'b1, idx: `BCCE_LINK_IDX,
                           data: link_val};                         // RULE5
               pc_d    = rd_a_data;                                 // RULE5
               redir_d = 1'b1;
            end
            bcce_pkg::BCCE_CMPEQ: begin
               wb_d = '{we: 1'b1, idx: dec.c_idx,
                        data: bcce_bool(eq_rr)};                    // RULE6
            end
            bcce_pkg::BCCE_CMPEQI: begin
               wb_d = '{we: 1'b1, idx: dec.b_idx,
                        data: bcce_bool(eq_ri)};                    // RULE8
            end
            default: begin
               wb_d = '0;
            end
         endcase
      end else begin
         pc_d = program_counter_q;
      end
   end

   // status copy and the jump happen together: both land on the same edge
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wb_q              <= '0;
         status_q          <= `BCCE_ST_RESET;
         status_load_q     <= 1'b0;
         program_counter_q <= `BCCE_PC_RESET;
         redirect_q        <= 1'b0;
      end else begin
         wb_q              <= wb_d;
         status_load_q     <= st_ld_d;
         program_counter_q <= pc_d;
         redirect_q        <= redir_d;
         if (st_ld_d) begin
            status_q <= saved_break_status;                         // RULE1
         end
      end
   end

   // instruction kinds as issued, used as antecedents below
   sequence bcce_bret_s;
      go && dec.op == bcce_pkg::BCCE_BRET;
   endsequence
   sequence bcce_call_s;
      go && (dec.op == bcce_pkg::BCCE_CALL
      || dec.op == bcce_pkg::BCCE_CALLR);
   endsequence
   sequence bcce_cmp_s;
      go && (dec.op == bcce_pkg::BCCE_CMPEQ
      || dec.op == bcce_pkg::BCCE_CMPEQI);
   endsequence
   // what calls and compares leave one edge after issue
   sequence bcce_jumped_s;
      redirect_q && !status_load_q;
   endsequence
   sequence bcce_stepped_s;
      !redirect_q && !status_load_q && wb_q.we;
   endsequence

   bret_load_a: assert property ( // RULE1
      @(posedge clk_sys) disable iff (!resetn)
      go && dec.op == bcce_pkg::BCCE_BRET |=> status_load_q && redirect_q
      && status_q == $past(saved_break_status)
      && program_counter_q == $past(break_return_address))
      else $error("breakpoint return wrong");
   call_link_a: assert property ( // RULE2
      @(posedge clk_sys) disable iff (!resetn)
      go && dec.op == bcce_pkg::BCCE_CALL |=> wb_q.we
      && wb_q.idx == 5'h1F
      && wb_q.data == $past(program_counter_q) + 32'h0000_0004)
      else $error("call link wrong");
   call_target_a: assert property ( // RULE3
      @(posedge clk_sys) disable iff (!resetn)
      go && dec.op == bcce_pkg::BCCE_CALL |=>
      program_counter_q[31:28] == $past(program_counter_q[31:28])
      && program_counter_q[27:0] == {$past(instr[31:6]), 2'b00})
      else $error("call target wrong");
   call_unsigned_a: assert property ( // RULE4
      @(posedge clk_sys) disable iff (!resetn)
      go && dec.op == bcce_pkg::BCCE_CALL && instr[31] |=>
      program_counter_q[31:28] == $past(program_counter_q[31:28])
      && program_counter_q[27])
      else $error("call field extended");
   callr_jump_a: assert property ( // RULE5
      @(posedge clk_sys) disable iff (!resetn)
      go && dec.op == bcce_pkg::BCCE_CALLR |=> redirect_q
      && program_counter_q == $past(rd_a_data) && wb_q.idx == 5'h1F
      && wb_q.data == $past(program_counter_q) + 32'h0000_0004)
      else $error("register call wrong");
   call_kind_a: assert property ( // RULE5
      @(posedge clk_sys) disable iff (!resetn)
      bcce_call_s |=> bcce_jumped_s ##0 (wb_q.we && wb_q.idx == 5'h1F))
      else $error("call did not jump and link");
   cmpeq_res_a: assert property ( // RULE6
      @(posedge clk_sys) disable iff (!resetn)
      go && dec.op == bcce_pkg::BCCE_CMPEQ |=> wb_q.we
      && wb_q.idx == $past(instr[21:17])
      && wb_q.data == {31'h0, $past(rd_a_data == rd_b_data)})
      else $error("compare equal wrong");
   cmp_step_a: assert property ( // RULE6
      @(posedge clk_sys) disable iff (!resetn)
      bcce_cmp_s |=> bcce_stepped_s ##0 (wb_q.data[31:1] == 31'h0000_0000
      && program_counter_q == $past(program_counter_q) + 32'h0000_0004))
      else $error("compare did not step");
   cmpeqi_sext_a: assert property ( // RULE7
      @(posedge clk_sys) disable iff (!resetn)
      go && dec.op == bcce_pkg::BCCE_CMPEQI && instr[21]
      && rd_a_data[31:16] == 16'h0000 |=> wb_q.data == 32'h0)
      else $error("immediate not extended");
   cmpeqi_res_a: assert property ( // RULE8
      @(posedge clk_sys) disable iff (!resetn)
      go && dec.op == bcce_pkg::BCCE_CMPEQI |=> wb_q.we
      && wb_q.idx == $past(instr[26:22])
      && wb_q.data[0] == $past(rd_a_data[15:0] == instr[21:6]
      && rd_a_data[31:16] == {16{instr[21]}}))
      else $error("compare immediate wrong");
   decode_kind_a: assert property ( // RULE10
      @(posedge clk_sys) disable iff (!resetn)
      go && instr[5:0] != 6'h3A && instr[5:0] != 6'h00
      && instr[5:0] != 6'h20 |=> !wb_q.we && !redirect_q)
      else $error("unknown opcode acted");

   // return leaves the register file alone and keeps its target
   bret_nowrite_a: assert property ( // RULE1
      @(posedge clk_sys) disable iff (!resetn)
      bcce_bret_s |=> !wb_q.we)
      else $error("return wrote a register");
   bret_settle_a: assert property ( // RULE1
      @(posedge clk_sys) disable iff (!resetn)
      bcce_bret_s ##1 !go |=> !status_load_q && !redirect_q
      && program_counter_q == $past(break_return_address, 2))
      else $error("return target not kept");
   status_hold_a: assert property ( // RULE1
      @(posedge clk_sys) disable iff (!resetn)
      !(go && dec.op == bcce_pkg::BCCE_BRET) |=> !status_load_q
      && $stable(status_q))
      else $error("status changed without return");
   // no instruction issued: nothing moves
   idle_hold_a: assert property ( // RULE10
      @(posedge clk_sys) disable iff (!resetn)
      !go |=> !redirect_q && !wb_q.we
      && program_counter_q == $past(program_counter_q))
      else $error("idle cycle acted");
endmodule
`default_nettype wire

// ===== design/bcce_pkg.sv
`default_nettype none
package bcce_pkg;
   typedef enum logic [2:0] {
      BCCE_NONE, BCCE_BRET, BCCE_CALL, BCCE_CALLR, BCCE_CMPEQ, BCCE_CMPEQI
   } bcce_op_t;
   typedef struct packed {
      bcce_op_t    op;
      logic [4:0]  a_idx;
      logic [4:0]  b_idx;
      logic [4:0]  c_idx;
      logic [15:0] immediate_sixteen;
      logic [25:0] jump_target_field;
   } bcce_dec_t;
   typedef struct packed {
      logic        we;
      logic [4:0]  idx;
      logic [31:0] data;
   } bcce_wb_t;
endpackage
`default_nettype wire

// ===== tb/branch_call_compare_exec_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "bcce_consts.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
   $display("[ERR] %0t got %h want %h", $time, g, e); end end
module branch_call_compare_exec_tb;
   logic               clk_sys;
   logic               resetn;
   logic               instr_valid;
   logic [31:0]        instr;
   logic [31:0]        rd_a_data;
   logic [31:0]        rd_b_data;
   logic [31:0]        saved_status;
   logic [31:0]        ret_addr;
   logic [4:0]         rd_a_idx;
   logic [4:0]         rd_b_idx;
   bcce_pkg::bcce_wb_t wb_q;
   logic [31:0]        status_q;
   logic               status_load_q;
   logic [31:0]        pc_q;
   logic               redirect_q;
   int                 err_total;
   int                 n_checks;
   bcce_exec uut (.clk_sys(clk_sys), .resetn(resetn),
      .instr_valid(instr_valid), .instr(instr), .rd_a_data(rd_a_data),
      .rd_b_data(rd_b_data), .saved_break_status(saved_status),
      .break_return_address(ret_addr), .rd_a_idx(rd_a_idx),
      .rd_b_idx(rd_b_idx), .wb_q(wb_q), .status_q(status_q),
      .status_load_q(status_load_q), .program_counter_q(pc_q),
      .redirect_q(redirect_q));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // issue one instruction, results settle one edge later
   task go(input logic [31:0] w, input logic [31:0] op_a,
           input logic [31:0] op_b);
      @(posedge clk_sys);
      #1;
      instr_valid = 1'b1;
      instr = w;
      rd_a_data = op_a;
      rd_b_data = op_b;
      #1;
      `CHK(rd_a_idx, w[31:27])
      `CHK(rd_b_idx, w[26:22])
      @(posedge clk_sys);
      #1;
      instr_valid = 1'b0;
   endtask
   task wb(input logic we, input logic [4:0] idx, input logic [31:0] d);
      `CHK(wb_q.we, we)
      if (we) begin
         `CHK(wb_q.idx, idx)
         `CHK(wb_q.data, d)
      end
   endtask
   task t_bret();
      saved_status = 32'h5A5A_0001;
      ret_addr = 32'hA000_0010;
      go({5'h1E, 10'h000, `BCCE_OPX_BRET, 5'h00, `BCCE_OP_RTYPE},
         32'h0, 32'h0);
      `CHK(status_q, 32'h5A5A_0001)
      `CHK(status_load_q, 1'b1)
      `CHK(pc_q, 32'hA000_0010)
      `CHK(redirect_q, 1'b1)
      $display("bret done");
   endtask
   task t_call();
      go({26'h200_0001, `BCCE_OP_CALL}, 32'h0, 32'h0);
      wb(1'b1, 5'h1F, 32'hA000_0014);
      `CHK(pc_q, 32'hA800_0004)
      go({5'h06, 5'h00, 5'h1F, `BCCE_OPX_CALLR, 5'h00, `BCCE_OP_RTYPE},
         32'h1234_5678, 32'h0);
      wb(1'b1, 5'h1F, 32'hA800_0008);
      `CHK(pc_q, 32'h1234_5678)
      `CHK(redirect_q, 1'b1)
      $display("call done");
   endtask
   task t_cmp();
      go({5'h07, 5'h00, 5'h06, `BCCE_OPX_CMPEQ, 5'h00, `BCCE_OP_RTYPE},
         32'h0000_0000, 32'h0000_0000);
      wb(1'b1, 5'h06, 32'h1);
      `CHK(pc_q, 32'h1234_567C)
      go({5'h07, 5'h00, 5'h06, `BCCE_OPX_CMPEQ, 5'h00, `BCCE_OP_RTYPE},
         32'h0000_0005, 32'h0000_0000);
      wb(1'b1, 5'h06, 32'h0);
      go({5'h07, 5'h03, 5'h06, `BCCE_OPX_CMPEQ, 5'h00, `BCCE_OP_RTYPE},
         32'h0000_0005, 32'h0000_0004);
      wb(1'b1, 5'h06, 32'h0);
      go({5'h07, 5'h09, 16'h8000, `BCCE_OP_CMPEQI}, 32'hFFFF_8000, 32'h0);
      wb(1'b1, 5'h09, 32'h1);
      go({5'h07, 5'h09, 16'h8000, `BCCE_OP_CMPEQI}, 32'h0000_8000, 32'h0);
      wb(1'b1, 5'h09, 32'h0);
      go({26'h0, 6'h3F}, 32'h0, 32'h0);
      wb(1'b0, 5'h00, 32'h0);
      `CHK(redirect_q, 1'b0)
      `CHK(pc_q, 32'h1234_5690)
      $display("compare done");
   endtask
   task close_out();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      #20000;
      err_total++;
      close_out();
   end
   initial begin
      err_total = 0;
      n_checks = 0;
      resetn = 1'b0;
      instr_valid = 1'b0;
      instr = 32'h0;
      rd_a_data = 32'h0;
      rd_b_data = 32'h0;
      saved_status = 32'h0;
      ret_addr = 32'h0;
      repeat (12) @(posedge clk_sys);
      #1;
      `CHK(pc_q, 32'h0)
      `CHK(status_q, 32'h0)
      `CHK(wb_q.we, 1'b0)
      `CHK(redirect_q, 1'b0)
      `CHK(status_load_q, 1'b0)
      resetn = 1'b1;
      t_bret();
      t_call();
      t_cmp();
      close_out();
   end
endmodule
`default_nettype wire
